// [logic/gdil_core.sv]
// Notes on behaviour
// - standby or fault drives all gates low, then locks the high side
// - a short low-side pulse arms recovery even if gates do not switch
// - low-side outputs follow inputs only while both enables are high
// - phase inputs are edge sensitive; low rise re-arms locked high side
// - high edge before low arming leaves the high side locked
// - all high inputs low together turns all high gates on
// - after initialization high gates are off and normal control runs
// - shared high and low input per phase works correctly
// - reset release powers up into standby with enables low
// - bytes 0010 xxxx and 0011 xxxx write the interrupt masks
// - mode command with lock bit applies mode then rejects changes
// - high inputs active low, low inputs active high
// - command response returns in the following transfer
// - gates keep following inputs once initialized until an enable drops or a fault
//
// Our own choices: the Wishbone interface to the registers and the address map.
module gdil_core #(
  parameter int WAKE_CYC = gdil_pkg::WAKE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // enables and fault pins
  input wire logic enable_first_i,
  input wire logic enable_second_i,
  input wire logic fault_i,
  // phase inputs
  input wire logic [2:0] phase_low_in_i,
  input wire logic [2:0] phase_high_in_n_i,
  // gate drive outputs
  output logic [2:0] low_gate_o,
  output logic [2:0] high_gate_out_o
);
  // ==========================================================
  // declarations
  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYC - 1);

  gdil_pkg::gdil_state_t state_reg, state_next;
  gdil_pkg::gdil_irq_t irq_reg, irq_set, irq_clr;
  logic en1_s1_reg, en1_s2_reg, en2_s1_reg, en2_s2_reg;
  logic flt_s1_reg, flt_s2_reg;
  logic en_both, run, low_en;
  logic [CW-1:0] wake_cnt_reg;
  logic [2:0] low_rise, early_high, unlocked;
  logic [3:0] mask0_reg, mask1_reg;
  logic [2:0] mode_reg;
  logic mode_lock_reg;
  logic [7:0] cmd_last_reg, pend_reg, resp_reg, resp_now;
  logic bus_req, bus_wr, cmd_wr;
  logic [7:0] cmd;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en1_s1_reg <= 1'b0;
      en1_s2_reg <= 1'b0;
      en2_s1_reg <= 1'b0;
      en2_s2_reg <= 1'b0;
      flt_s1_reg <= 1'b0;
      flt_s2_reg <= 1'b0;
    end else begin
      en1_s1_reg <= enable_first_i;
      en1_s2_reg <= en1_s1_reg;
      en2_s1_reg <= enable_second_i;
      en2_s2_reg <= en2_s1_reg;
      flt_s1_reg <= fault_i;
      flt_s2_reg <= flt_s1_reg;
    end
  end

  assign en_both = en1_s2_reg & en2_s2_reg;
  assign low_en = en_both & (state_reg != gdil_pkg::ST_FAULT) & ~flt_s2_reg;
  assign run = (state_reg == gdil_pkg::ST_NORMAL);

  // ==========================================================
  // operating state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      gdil_pkg::ST_STANDBY: begin
        if (en_both)
          state_next = gdil_pkg::ST_WAKE;
      end
      gdil_pkg::ST_WAKE: begin
        // edges ignored until wake time is over
        if (!en_both)
          state_next = gdil_pkg::ST_STANDBY;
        else if (wake_cnt_reg == WAKE_LAST)
          state_next = gdil_pkg::ST_NORMAL;
      end
      gdil_pkg::ST_NORMAL: begin
        if (!en_both)
          state_next = gdil_pkg::ST_STANDBY;
      end
      gdil_pkg::ST_FAULT: begin
        // leave only after the fault flag is cleared
        if (!flt_s2_reg && !irq_reg.fault)
          state_next = gdil_pkg::ST_STANDBY;
      end
      default: state_next = gdil_pkg::ST_STANDBY;
    endcase
    if (flt_s2_reg)
      state_next = gdil_pkg::ST_FAULT;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_reg <= gdil_pkg::ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // wake delay counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != gdil_pkg::ST_WAKE)
      wake_cnt_reg <= '0;
    else if (wake_cnt_reg != WAKE_LAST)
      wake_cnt_reg <= wake_cnt_reg + CW'(1);
  end

  // ==========================================================
  // phase channels
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      gdil_phase u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_low_in_i(phase_low_in_i[gi]),
        .phase_high_in_n_i(phase_high_in_n_i[gi]),
        .low_en_i(low_en),
        .run_i(run),
        .low_gate_o(low_gate_o[gi]),
        .high_gate_out_o(high_gate_out_o[gi]),
        .low_rise_o(low_rise[gi]),
        .early_high_o(early_high[gi]),
        .unlocked_o(unlocked[gi])
      );
    end
  endgenerate

  // ==========================================================
  // wishbone slave
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign cmd_wr = bus_wr & wb_sel_i[0] & (wb_adr_i == gdil_pkg::ADR_CMD);
  assign cmd = wb_dat_i[7:0];

  // ack one cycle after request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // read data, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        gdil_pkg::ADR_CMD: wb_dat_o <= {24'h000000, cmd_last_reg};
        gdil_pkg::ADR_RESP: wb_dat_o <= {24'h000000, resp_reg};
        gdil_pkg::ADR_STAT:
          wb_dat_o <= {19'h00000, mode_lock_reg, mode_reg, unlocked,
                       low_en, run, state_reg};
        gdil_pkg::ADR_FLAG:
          wb_dat_o <= {20'h00000, mask1_reg, mask0_reg, irq_reg};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // command decode: masks, mode and lock
  // mask writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask0_reg <= gdil_pkg::MASK_RST;
      mask1_reg <= gdil_pkg::MASK_RST;
    end else if (cmd_wr) begin
      if (cmd[7:4] == gdil_pkg::CMD_MASK0)
        mask0_reg <= cmd[3:0];
      if (cmd[7:4] == gdil_pkg::CMD_MASK1)
        mask1_reg <= cmd[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= gdil_pkg::MODE_RST;
      mode_lock_reg <= 1'b0;
    end else if (cmd_wr && cmd[7:4] == gdil_pkg::CMD_MODE &&
                 !mode_lock_reg) begin
      mode_reg <= cmd[3:1];
      mode_lock_reg <= cmd[gdil_pkg::MODE_LOCK_BIT];
    end
  end

  // ==========================================================
  // interrupt flags, set wins over clear
  always_comb begin
    irq_set = '0;
    irq_clr = '0;
    irq_set.fault = flt_s2_reg;
    irq_set.mode_reject = cmd_wr && cmd[7:4] == gdil_pkg::CMD_MODE &&
                          mode_lock_reg;
    irq_set.early_low = (state_reg == gdil_pkg::ST_WAKE) && (|low_rise);
    irq_set.early_high = |early_high;
    if (cmd_wr && cmd[7:4] == gdil_pkg::CMD_CLR0) begin
      irq_clr.fault = cmd[0];
      irq_clr.mode_reject = cmd[1];
    end
    if (cmd_wr && cmd[7:4] == gdil_pkg::CMD_CLR1) begin
      irq_clr.early_low = cmd[0];
      irq_clr.early_high = cmd[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_reg <= '0;
    else
      irq_reg <= irq_set | (irq_reg & ~irq_clr);
  end

  // ==========================================================
  // response pipeline
  always_comb begin
    case (cmd)
      gdil_pkg::CMD_QUERY0: resp_now = {mask0_reg, 2'b00, irq_reg[1:0]};
      gdil_pkg::CMD_QUERY1: resp_now = {mask1_reg, 2'b00, irq_reg[3:2]};
      default: resp_now = {state_reg, unlocked, mode_lock_reg};
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_last_reg <= gdil_pkg::RESP_RST;
      pend_reg <= gdil_pkg::RESP_RST;
      resp_reg <= gdil_pkg::RESP_RST;
    end else if (cmd_wr) begin
      cmd_last_reg <= cmd;
      pend_reg <= resp_now;
      resp_reg <= pend_reg;
    end
  end

  // ==========================================================
  // assertions
  sequence s_fault_seen;
    flt_s2_reg;
  endsequence

  sequence s_shut;
    state_reg == gdil_pkg::ST_FAULT ##1
      (low_gate_o == 3'h0 && high_gate_out_o == 3'h0 && unlocked == 3'h0);
  endsequence

  a_fault_shutdown: assert property (@(posedge clk_i)
    disable iff (rst_i) s_fault_seen |=> s_shut)
    else $error("fault did not shut gates and lock");
  a_idle_locked: assert property (@(posedge clk_i)
    disable iff (rst_i) !run |=> unlocked == 3'h0)
    else $error("high side left unlocked outside normal control");
  a_fault_flag: assert property (@(posedge clk_i)
    disable iff (rst_i) flt_s2_reg |=> irq_reg.fault)
    else $error("fault flag not raised");
  a_low_enable: assert property (@(posedge clk_i)
    disable iff (rst_i) !en_both |=> low_gate_o == 3'h0)
    else $error("low gate on without both enables");
  a_wake_time: assert property (@(posedge clk_i)
    disable iff (rst_i) run && !$past(run) |-> $past(wake_cnt_reg) == WAKE_LAST)
    else $error("normal entered before wake delay");
  a_early_low_flag: assert property (@(posedge clk_i)
    disable iff (rst_i)
    state_reg == gdil_pkg::ST_WAKE && (|low_rise) |=> irq_reg.early_low)
    else $error("low edge during wake not flagged");
  a_reset_standby: assert property (@(posedge clk_i)
    rst_i |=> state_reg == gdil_pkg::ST_STANDBY && wb_ack_o == 1'b0)
    else $error("reset did not enter standby");
  // command, flag, normal control and high gate checks
  a_mask_write: assert property (@(posedge clk_i)
    disable iff (rst_i) cmd_wr && cmd[7:4] == gdil_pkg::CMD_MASK0 |=>
      mask0_reg == $past(cmd[3:0]))
    else $error("mask write lost");
  a_mask1_write: assert property (@(posedge clk_i)
    disable iff (rst_i) cmd_wr && cmd[7:4] == gdil_pkg::CMD_MASK1 |=>
      mask1_reg == $past(cmd[3:0]))
    else $error("second mask write lost");
  a_mode_apply: assert property (@(posedge clk_i)
    disable iff (rst_i)
    cmd_wr && cmd[7:4] == gdil_pkg::CMD_MODE && !mode_lock_reg |=>
      mode_reg == $past(cmd[3:1]) && mode_lock_reg == $past(cmd[0]))
    else $error("mode command not applied");
  a_mode_locked: assert property (@(posedge clk_i)
    disable iff (rst_i) mode_lock_reg |=> mode_lock_reg && $stable(mode_reg))
    else $error("mode changed after lock");
  a_mode_reject: assert property (@(posedge clk_i)
    disable iff (rst_i) cmd_wr && cmd[7:4] == gdil_pkg::CMD_MODE &&
      mode_lock_reg |=> irq_reg.mode_reject)
    else $error("locked mode change not flagged");
  a_resp_delay: assert property (@(posedge clk_i)
    disable iff (rst_i) cmd_wr |=>
      resp_reg == $past(pend_reg) && pend_reg == $past(resp_now))
    else $error("response not shifted by one transfer");
  a_stay_normal: assert property (@(posedge clk_i)
    disable iff (rst_i) run && en_both && !flt_s2_reg |=> run)
    else $error("normal control dropped without cause");
  a_all_high_on: assert property (@(posedge clk_i)
    disable iff (rst_i)
    run && unlocked == 3'h7 && phase_high_in_n_i == 3'h0 ##1
      (run && unlocked == 3'h7 && phase_high_in_n_i == 3'h0)[*2]
      |=> high_gate_out_o == 3'h7)
    else $error("high gates not on together");
  a_high_off_init: assert property (@(posedge clk_i)
    disable iff (rst_i)
    phase_high_in_n_i == 3'h7 ##1 phase_high_in_n_i == 3'h7 ##1
      phase_high_in_n_i == 3'h7 |=> high_gate_out_o == 3'h0)
    else $error("high gate on with inputs high");
endmodule : gdil_core

// [common/gdil_pkg.sv]
package gdil_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WAKE_NS = 280;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARM_PULSE_NS = 100;
  localparam int ARM_PULSE_CYC = ARM_PULSE_NS / CLK_PERIOD_NS;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [3:0] ADR_CMD = 4'h0;
  localparam logic [3:0] ADR_RESP = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  localparam logic [3:0] ADR_FLAG = 4'hc;

  // ==========================================================
  // command byte encodings
  localparam logic [7:0] CMD_QUERY0 = 8'h00;
  localparam logic [7:0] CMD_QUERY1 = 8'h01;
  localparam logic [3:0] CMD_MASK0 = 4'h2;
  localparam logic [3:0] CMD_MASK1 = 4'h3;
  localparam logic [3:0] CMD_MODE = 4'h4;
  localparam logic [3:0] CMD_CLR0 = 4'h6;
  localparam logic [3:0] CMD_CLR1 = 4'h7;
  localparam int MODE_LOCK_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] RESP_RST = 8'h00;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_WAKE = 4'b0010,
    ST_NORMAL = 4'b0100,
    ST_FAULT = 4'b1000
  } gdil_state_t;

  // group one in the upper pair, group zero in the lower pair
  typedef struct packed {
    logic early_high;
    logic early_low;
    logic mode_reject;
    logic fault;
  } gdil_irq_t;
endpackage : gdil_pkg

// [logic/gdil_phase.sv]
// one phase: input sampling, edge detect, arming and high-side lockout
module gdil_phase (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins, asynchronous
  input wire logic phase_low_in_i,
  input wire logic phase_high_in_n_i,
  // control from the core
  input wire logic low_en_i,
  input wire logic run_i,
  // gate drive and events
  output logic low_gate_o,
  output logic high_gate_out_o,
  output logic low_rise_o,
  output logic early_high_o,
  output logic unlocked_o
);
  // ==========================================================
  // synchronisers and previous samples
  logic low_s1_reg, low_s2_reg, low_prev_reg;
  logic high_s1_reg, high_s2_reg, high_prev_reg;
  logic armed_reg;
  logic low_rise, high_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_s1_reg <= 1'b0;
      low_s2_reg <= 1'b0;
      low_prev_reg <= 1'b0;
      high_s1_reg <= 1'b1;
      high_s2_reg <= 1'b1;
      high_prev_reg <= 1'b1;
    end else begin
      low_s1_reg <= phase_low_in_i;
      low_s2_reg <= low_s1_reg;
      low_prev_reg <= low_s2_reg;
      high_s1_reg <= phase_high_in_n_i;
      high_s2_reg <= high_s1_reg;
      high_prev_reg <= high_s2_reg;
    end
  end

  assign low_rise = low_s2_reg & ~low_prev_reg;
  assign high_fall = ~high_s2_reg & high_prev_reg;

  // arming and unlocking, both dropped whenever not running
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      armed_reg <= 1'b0;
      unlocked_o <= 1'b0;
    end else begin
      if (low_rise)
        armed_reg <= 1'b1;
      // high edge before arming is ignored
      if (armed_reg && high_fall)
        unlocked_o <= 1'b1;
    end
  end

  // gate outputs and event pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_gate_o <= 1'b0;
      high_gate_out_o <= 1'b0;
      low_rise_o <= 1'b0;
      early_high_o <= 1'b0;
    end else begin
      // low active high, high active low
      low_gate_o <= low_en_i & low_s2_reg;
      high_gate_out_o <= run_i & unlocked_o & ~high_s2_reg;
      low_rise_o <= low_rise;
      early_high_o <= run_i & high_fall & ~armed_reg & ~unlocked_o;
    end
  end

  // ==========================================================
  // assertions
  sequence s_armed;
    run_i && armed_reg && high_fall;
  endsequence

  a_arm_then_unlock: assert property (@(posedge clk_i)
    disable iff (rst_i) s_armed ##1 run_i |-> unlocked_o)
    else $error("armed high edge did not unlock");
  a_early_high_lock: assert property (@(posedge clk_i)
    disable iff (rst_i) run_i && !armed_reg && !unlocked_o |=> !unlocked_o)
    else $error("high side unlocked before arming");
  a_short_arm: assert property (@(posedge clk_i)
    disable iff (rst_i) run_i && low_rise ##1 run_i |-> armed_reg)
    else $error("low rise did not arm");
  a_shared_level: assert property (@(posedge clk_i)
    disable iff (rst_i)
    low_s2_reg == high_s2_reg |=> !(low_gate_o && high_gate_out_o))
    else $error("both gates on from shared level");
endmodule : gdil_phase

// [tb/gdil_host.sv]
// host side of the phase pins and enables
module gdil_host #(
  parameter int WAKE_CYC = 4,
  parameter int ARM_CYC = 20
) (
  // clock
  input wire logic clk_i,
  // enables, bit 0 first, bit 1 second
  output logic [1:0] enable_o,
  // phase inputs
  output logic [2:0] phase_low_o,
  output logic [2:0] phase_high_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle levels: enables low, high sides off
  // high inputs idle high
  initial begin
    enable_o = 2'b00;
    phase_low_o = 3'h0;
    phase_high_n_o = 3'h7;
  end

  // ==========================================================
  // enables, then wait past the wake delay before any phase edge
  // enables after setup
  task automatic set_en(input logic [1:0] en);
    @(posedge clk_i);
    enable_o <= en;
    repeat (WAKE_CYC + 8) @(posedge clk_i);
  endtask : set_en

  // enables with no wait, to probe a low edge inside the wake delay
  // early edge probe
  task automatic set_en_now(input logic [1:0] en);
    @(posedge clk_i);
    enable_o <= en;
  endtask : set_en_now

  // pin levels held for a number of cycles
  // held pin levels
  task automatic pins(input logic [2:0] lo, input logic [2:0] hi_n,
                      input int cyc);
    @(posedge clk_i);
    phase_low_o <= lo;
    phase_high_n_o <= hi_n;
    repeat (cyc) @(posedge clk_i);
  endtask : pins

  // short arming pulse on all low inputs
  // minimum arming pulse
  task automatic arm();
    pins(3'h7, 3'h7, ARM_CYC);
    pins(3'h0, 3'h7, 4);
  endtask : arm
endmodule : gdil_host

// [tb/tb_gate_drive_init_lockout.sv]
// self-checking bench for the gate drive core
module tb_gate_drive_init_lockout;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  logic clk_i;
  logic rst_i;
  logic wb_cyc, wb_stb, wb_we, fault;
  logic [3:0] wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] en;
  logic [2:0] lo_in, hi_n_in, low_gate_o, high_gate_out_o;
  int n_mismatch = 0;
  int tests_run = 0;

  // ==========================================================
  // design and host
  gdil_core #(.WAKE_CYC(4)) gdil_core_i (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .enable_first_i(en[0]), .enable_second_i(en[1]), .fault_i(fault),
    .phase_low_in_i(lo_in), .phase_high_in_n_i(hi_n_in),
    .low_gate_o(low_gate_o), .high_gate_out_o(high_gate_out_o)
  );

  gdil_host #(.WAKE_CYC(4), .ARM_CYC(gdil_pkg::ARM_PULSE_CYC)) gdil_host_i (
    .clk_i(clk_i), .enable_o(en),
    .phase_low_o(lo_in), .phase_high_n_o(hi_n_in)
  );

  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // classic cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [7:0] c);
    logic [31:0] q;
    wb(1'b1, gdil_pkg::ADR_CMD, {24'h0, c}, q);
  endtask : cmd

  task automatic rd(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd

  // gates reach the expected levels within a bounded wait
  task automatic chkg(input logic [2:0] lo, input logic [2:0] hi);
    int n;
    n = 0;
    while ({low_gate_o, high_gate_out_o} !== {lo, hi} && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk({26'h0, low_gate_o, high_gate_out_o}, {26'h0, lo, hi});
  endtask : chkg

  // ==========================================================
  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    logic [31:0] q;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    fault = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(gdil_pkg::ADR_STAT, 32'hffffffff, 32'h00000001);
    rd(gdil_pkg::ADR_FLAG, 32'hffffffff, 32'h00000000);
    chkg(3'h0, 3'h0);
    $display("test reset done");
    // flag clears, masks, locked mode, delayed response
    cmd(8'h60);
    cmd(8'h70);
    cmd(8'h25);
    cmd(8'h3a);
    rd(gdil_pkg::ADR_FLAG, 32'hffffffff, 32'h00000a50);
    cmd(8'h47);
    rd(gdil_pkg::ADR_STAT, 32'h00001e0f, 32'h00001601);
    cmd(8'h48);
    rd(gdil_pkg::ADR_STAT, 32'h00001e0f, 32'h00001601);
    rd(gdil_pkg::ADR_FLAG, 32'hffffffff, 32'h00000a52);
    cmd(8'h00);
    cmd(8'h01);
    rd(gdil_pkg::ADR_RESP, 32'h000000ff, 32'h00000052);
    wb(1'b1, gdil_pkg::ADR_RESP, 32'h000000ff, q);
    rd(gdil_pkg::ADR_CMD, 32'h000000ff, 32'h00000001);
    cmd(8'h63);
    rd(gdil_pkg::ADR_FLAG, 32'hffffffff, 32'h00000a50);
    $display("test registers done");
    // high edge before arming stays locked
    gdil_host_i.set_en(2'b11);
    rd(gdil_pkg::ADR_STAT, 32'h0000000f, 32'h00000004);
    gdil_host_i.pins(3'h0, 3'h0, 24);
    chkg(3'h0, 3'h0);
    rd(gdil_pkg::ADR_FLAG, 32'h00000008, 32'h00000008);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    cmd(8'h72);
    $display("test early high done");
    // bootstrap order, recirculation, normal control
    gdil_host_i.pins(3'h7, 3'h7, 200);
    chkg(3'h7, 3'h0);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    gdil_host_i.pins(3'h0, 3'h0, 24);
    chkg(3'h0, 3'h7);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    chkg(3'h0, 3'h0);
    gdil_host_i.pins(3'h0, 3'h6, 8);
    chkg(3'h0, 3'h1);
    $display("test init done");
    // one shared level per phase
    gdil_host_i.pins(3'h5, 3'h5, 10);
    chkg(3'h5, 3'h2);
    gdil_host_i.pins(3'h2, 3'h2, 10);
    chkg(3'h2, 3'h5);
    gdil_host_i.pins(3'h0, 3'h7, 6);
    $display("test shared done");
    // fault shuts down, relock, short pulse recovery
    gdil_host_i.pins(3'h0, 3'h0, 10);
    @(posedge clk_i);
    fault <= 1'b1;
    chkg(3'h0, 3'h0);
    rd(gdil_pkg::ADR_STAT, 32'h0000000f, 32'h00000008);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    fault <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmd(8'h61);
    repeat (16) @(posedge clk_i);
    rd(gdil_pkg::ADR_STAT, 32'h0000000f, 32'h00000004);
    gdil_host_i.pins(3'h0, 3'h0, 24);
    chkg(3'h0, 3'h0);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    gdil_host_i.arm();
    gdil_host_i.pins(3'h0, 3'h0, 24);
    chkg(3'h0, 3'h7);
    gdil_host_i.pins(3'h0, 3'h7, 6);
    $display("test fault done");
    // low side needs both enables
    gdil_host_i.set_en(2'b01);
    gdil_host_i.pins(3'h7, 3'h7, 12);
    chkg(3'h0, 3'h0);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    $display("test enables done");
    // low edge inside the wake delay is not honoured
    gdil_host_i.set_en_now(2'b11);
    gdil_host_i.pins(3'h7, 3'h7, 4);
    gdil_host_i.pins(3'h0, 3'h0, 24);
    chkg(3'h0, 3'h0);
    rd(gdil_pkg::ADR_FLAG, 32'h00000004, 32'h00000004);
    cmd(8'h73);
    rd(gdil_pkg::ADR_FLAG, 32'h0000000c, 32'h00000000);
    gdil_host_i.pins(3'h0, 3'h7, 4);
    $display("test early low done");
    end_sim();
  end
endmodule : tb_gate_drive_init_lockout
